// ===== rtl/oask_pkg.sv
// package: constants and carrier types for operand addressing and skip timing
package oask_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_OPCODE  = 12'h004;
	localparam logic [11:0] ADDR_PC      = 12'h008;
	localparam logic [11:0] ADDR_RESULT  = 12'h00C;
	localparam logic [11:0] ADDR_SKIP    = 12'h010;

	// ==========================================================
	// control register fields
	localparam int CTRL_MBE_BIT    = 0;
	localparam int CTRL_MBS_LSB    = 4;
	localparam int CTRL_ENH_BIT    = 8;
	localparam int CTRL_PCC_LSB    = 12;
	localparam int CTRL_BIG_BIT    = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ==========================================================
	// data memory areas
	localparam logic [3:0]  BANK0          = 4'h0;
	localparam logic [3:0]  BANK1          = 4'h1;
	localparam logic [3:0]  BANK15         = 4'hF;
	localparam logic [7:0]  LOW_DIRECT_MAX = 8'h7F;
	localparam logic [11:0] FMEM_LO_BASE   = 12'hFB0;
	localparam logic [11:0] FMEM_HI_BASE   = 12'hFF0;
	localparam logic [11:0] PMEM_BASE      = 12'hFC0;

	// ==========================================================
	// program memory areas
	localparam logic [12:0] TADDR_MIN = 13'h0020;
	localparam logic [12:0] TADDR_MAX = 13'h007F;
	localparam int REL_BACK_MAX = 15;
	localparam int REL_FWD_MIN  = 2;
	localparam int REL_FWD_MAX  = 16;

	// ==========================================================
	// skip penalty cycles
	localparam logic [1:0] SKIP_NONE  = 2'd0;
	localparam logic [1:0] SKIP_SHORT = 2'd1;
	localparam logic [1:0] SKIP_LONG  = 2'd2;

	// ==========================================================
	// operand kinds presented to the decoder
	typedef enum logic [3:0] {
		OASK_OP_REG, OASK_OP_NON_ACCUMULATOR_REGISTER, OASK_OP_RPX, OASK_OP_RPX1,
		OASK_OP_IND, OASK_OP_IND1, OASK_OP_MEM, OASK_OP_FMEM,
		OASK_OP_PMEM, OASK_OP_ADDR, OASK_OP_EXTENDED_ABSOLUTE_OPERAND, OASK_OP_CADDR,
		OASK_OP_FADDR, OASK_OP_TADDR, OASK_OP_REL, OASK_OP_IMM
	} oask_kind_t;

	// decoded operand result
	typedef struct packed {
		logic        legal;
		logic [3:0]  bank;
		logic [12:0] addr;
		logic [3:0]  nibble;
		logic [7:0]  byte_imm;
		logic [1:0]  bitsel;
		logic [2:0]  regsel;
	} oask_result_t;

endpackage : oask_pkg

// ===== rtl/oask_skip_timer.sv
// skip timer: counts the extra machine cycles of a skipped instruction
`timescale 1ns/10ps
module oask_skip_timer (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       start,
	input  wire logic       taken,
	input  wire logic       three_byte,
	output logic            busy,
	output logic [1:0]      penalty,
	output logic            done
);
	logic [1:0] remain;
	wire  [1:0] next_penalty;

	// pick the penalty: no skip costs nothing, long forms cost two
	assign next_penalty = !taken ? oask_pkg::SKIP_NONE :
		(three_byte ? oask_pkg::SKIP_LONG : oask_pkg::SKIP_SHORT);
	assign busy = (remain != 2'd0);

	// one count per pclk edge, each edge is one machine cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain  <= 2'd0;
			penalty <= 2'd0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				penalty <= next_penalty;
				remain  <= next_penalty;
				done    <= (next_penalty == 2'd0);
			end else if (busy) begin
				remain <= remain - 2'd1;
				done   <= (remain == 2'd1);
			end
		end
	end
endmodule : oask_skip_timer

// ===== rtl/oask_decoder.sv
// operand addressing and skip timing decoder with apb register access
//
// Behaviour
// (RULE1) skip costs 0, 1 or 2 cycles
// (RULE2) only long branch and call forms are three-byte
// (RULE3) indirect bank is enable gating select
// (RULE4) direct bank: low half 0, high 15 (the code uses the select instead when enable is set)
// (RULE5) de and dl pointers always bank 0
// (RULE6) fixed and port bits always bank 15
// (RULE7) fixed bits only fb0-fbf, ff0-fff
// (RULE8) port bits only fc0-fff
// (RULE9) software keeps pair-wide direct address even
// (RULE10) accept nibble, byte and bit fields
// (RULE11) restricted register excludes accumulator
// (RULE12) restricted pair excludes primary accumulator pair
// (RULE13) pointer set hl, hl+, hl-, de, dl
// (RULE14) a, xa and carry are accumulators
// (RULE15) call table 0020-007f, even only
// (RULE16) short call eleven bits wide
// (RULE17) in-page branch twelve bits plus pc12
// (RULE18) relative targets -15..-1 and +2..+16
// (RULE19) extended absolute only in enhanced mode
// (RULE20) one machine cycle per clock
// (RULE21) skipped bytes change nothing, pc advances
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module oask_decoder #(
	parameter int PC_WIDTH = 13
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	// ==========================================================
	// apb decode
	logic [31:0]         ctrl;
	logic [31:0]         opcode;
	logic [PC_WIDTH-1:0] pc;
	oask_pkg::oask_result_t result;
	logic                pair_odd;

	wire acc      = psel && penable;
	wire wr       = acc && pwrite;
	wire hit_ctrl = (paddr == oask_pkg::ADDR_CTRL);
	wire hit_op   = (paddr == oask_pkg::ADDR_OPCODE);
	wire hit_pc   = (paddr == oask_pkg::ADDR_PC);
	wire hit_res  = (paddr == oask_pkg::ADDR_RESULT);
	wire hit_skip = (paddr == oask_pkg::ADDR_SKIP);
	wire mapped   = hit_ctrl | hit_op | hit_pc | hit_res | hit_skip;

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// control fields
	wire       data_bank_enable_flag = ctrl[oask_pkg::CTRL_MBE_BIT];
	wire [3:0] data_bank_select_reg  = ctrl[oask_pkg::CTRL_MBS_LSB +: 4];
	wire       enhanced_instruction_mode = ctrl[oask_pkg::CTRL_ENH_BIT];
	wire [1:0] cpu_clock_select_reg  = ctrl[oask_pkg::CTRL_PCC_LSB +: 2];
	wire       big_rom               = ctrl[oask_pkg::CTRL_BIG_BIT];

	// opcode fields: kind, selector and operand value
	wire [3:0]  kind_raw = opcode[31:28];
	wire [2:0]  sel      = opcode[26:24];
	wire [12:0] val      = opcode[12:0];
	wire        skip_req = opcode[27];
	wire        next_long = opcode[23];
	oask_pkg::oask_kind_t kind;
	assign kind = oask_pkg::oask_kind_t'(kind_raw);

	// ==========================================================
	// bank helper, used by the indirect decode only
	function automatic logic [3:0] gated_bank(input logic en,
		input logic [3:0] s);
		gated_bank = en ? s : oask_pkg::BANK0;
	endfunction : gated_bank

	function automatic logic bank_ok(input logic [3:0] b);
		bank_ok = (b == oask_pkg::BANK0) || (b == oask_pkg::BANK1) ||
			(b == oask_pkg::BANK15);
	endfunction : bank_ok

	// (RULE3) indirect bank gated by enable
	wire [3:0] ind_bank = gated_bank(data_bank_enable_flag,
		data_bank_select_reg);
	// (RULE4) direct bank from address half, or from select when enable set
	wire [3:0] dir_bank = data_bank_enable_flag ? data_bank_select_reg :
		((val[7:0] <= oask_pkg::LOW_DIRECT_MAX) ? oask_pkg::BANK0 :
		oask_pkg::BANK15);
	wire [11:0] dir_addr = {dir_bank, val[7:0]};

	// (RULE7) fixed-bit area check
	wire [11:0] fmem_a  = {4'hF, val[7:0]};
	wire fmem_ok = (fmem_a[11:4] == oask_pkg::FMEM_LO_BASE[11:4]) ||
		(fmem_a[11:4] == oask_pkg::FMEM_HI_BASE[11:4]);
	// (RULE8) port-bit area check
	wire pmem_ok = (fmem_a[11:6] == oask_pkg::PMEM_BASE[11:6]);

	// (RULE15) call table range and alignment
	wire taddr_ok = (val >= oask_pkg::TADDR_MIN) &&
		(val <= oask_pkg::TADDR_MAX) && !val[0];

	// (RULE18) relative offset: 5-bit signed, 0 and +1 decoded but illegal
	// code 10h would be -16, never legal, so it carries +16 instead
	wire signed [5:0] rel_off = (val[4:0] == 5'h10) ? 6'sd16 :
		$signed({val[4], val[4:0]});
	wire rel_ok = (rel_off >= -6'sd15 && rel_off <= -6'sd1) ||
		(rel_off >= 6'sd2 && rel_off <= 6'sd16);
	wire [12:0] rel_tgt = pc[12:0] + 13'($signed(rel_off));

	// (RULE17) in-page target keeps pc bit 12 on large parts
	wire [12:0] page_tgt = {big_rom & pc[12], val[11:0]};

	// ==========================================================
	// operand decode
	always_comb begin
		result = '0;
		result.nibble   = val[3:0];
		result.byte_imm = val[7:0];
		// (RULE10) bit selector in a nibble
		result.bitsel   = val[9:8];
		case (kind)
			oask_pkg::OASK_OP_REG: begin
				result.legal  = 1'b1;
				result.regsel = sel;
			end
			// (RULE11) code 1 is the accumulator, excluded
			oask_pkg::OASK_OP_NON_ACCUMULATOR_REGISTER: begin
				result.legal  = (sel != 3'd1);
				result.regsel = sel;
			end
			// (RULE12) pairs 0-3 primary, 4-7 alternate bank
			oask_pkg::OASK_OP_RPX: begin
				result.legal  = 1'b1;
				result.regsel = sel;
			end
			oask_pkg::OASK_OP_RPX1: begin
				result.legal  = (sel != 3'd0);
				result.regsel = sel;
			end
			// (RULE13) pointers 0..4; (RULE5) de/dl use bank 0
			oask_pkg::OASK_OP_IND: begin
				result.legal  = (sel <= 3'd4) && bank_ok(ind_bank);
				result.regsel = sel;
				result.bank   = (sel >= 3'd3) ? oask_pkg::BANK0 : ind_bank;
			end
			oask_pkg::OASK_OP_IND1: begin
				result.legal  = (sel == 3'd3) || (sel == 3'd4);
				result.regsel = sel;
				result.bank   = oask_pkg::BANK0;
			end
			oask_pkg::OASK_OP_MEM: begin
				result.legal = bank_ok(dir_bank);
				result.bank  = dir_bank;
				result.addr  = {1'b0, dir_addr};
			end
			// (RULE6) bit areas pinned to bank 15
			oask_pkg::OASK_OP_FMEM: begin
				result.legal = fmem_ok;
				result.bank  = oask_pkg::BANK15;
				result.addr  = {1'b0, fmem_a};
			end
			oask_pkg::OASK_OP_PMEM: begin
				result.legal = pmem_ok;
				result.bank  = oask_pkg::BANK15;
				result.addr  = {1'b0, fmem_a};
			end
			oask_pkg::OASK_OP_ADDR: begin
				result.legal = big_rom || !val[12];
				result.addr  = val;
			end
			// (RULE19) extended absolute needs enhanced mode
			oask_pkg::OASK_OP_EXTENDED_ABSOLUTE_OPERAND: begin
				result.legal = enhanced_instruction_mode &&
					(big_rom || !val[12]);
				result.addr  = val;
			end
			oask_pkg::OASK_OP_CADDR: begin
				result.legal = 1'b1;
				result.addr  = page_tgt;
			end
			// (RULE16) eleven-bit short call
			oask_pkg::OASK_OP_FADDR: begin
				result.legal = (val[12:11] == 2'b00);
				result.addr  = {2'b00, val[10:0]};
			end
			oask_pkg::OASK_OP_TADDR: begin
				result.legal = taddr_ok;
				result.addr  = val;
			end
			oask_pkg::OASK_OP_REL: begin
				result.legal = rel_ok;
				result.addr  = rel_tgt;
			end
			default: begin
				// (RULE14) immediates feed a, xa or carry
				result.legal = 1'b1;
			end
		endcase
	end

	// (RULE9) flag odd pair-wide direct address, software must avoid
	assign pair_odd = (kind == oask_pkg::OASK_OP_MEM) && val[0];

	// ==========================================================
	// skip timing
	logic       skip_busy;
	logic [1:0] skip_pen;
	logic       skip_done;
	logic       skip_pend;
	logic [PC_WIDTH-1:0] skip_bytes;
	wire start = skip_pend && !skip_busy;

	// (RULE2) opcode bit 23 marks the long branch/call forms
	// (RULE1) penalty chosen inside the timer
	// (RULE20) one count per pclk period
	oask_skip_timer u_skip (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (start),
		.taken      (skip_req),
		.three_byte (next_long),
		.busy       (skip_busy),
		.penalty    (skip_pen),
		.done       (skip_done)
	);

	// write a 1 to skip register to launch a skip of next instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_pend <= 1'b0;
		end else begin
			skip_pend <= wr && hit_skip && pwdata[0];
		end
	end

	// bytes to discard: 3 for long forms, else 1 or 2 by opcode bit 22
	assign skip_bytes = next_long ? PC_WIDTH'(3) :
		(opcode[22] ? PC_WIDTH'(2) : PC_WIDTH'(1));

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl   <= oask_pkg::CTRL_RESET;
			opcode <= 32'h0000_0000;
			pc     <= '0;
		end else begin
			if (wr && hit_ctrl)
				ctrl <= pwdata;
			if (wr && hit_op)
				opcode <= pwdata;
			// (RULE21) skip only advances pc, nothing else changes
			if (wr && hit_pc)
				pc <= pwdata[PC_WIDTH-1:0];
			else if (start && skip_req)
				pc <= pc + skip_bytes;
		end
	end

	// read mux, combinational data
	wire [31:0] rd_res = {pair_odd, 2'b00, result.legal, result.bank,
		result.bitsel, result.regsel, 6'd0, result.addr};
	wire [31:0] rd_val = hit_ctrl ? ctrl : hit_op ? opcode :
		hit_pc ? 32'(pc) : hit_res ? rd_res :
		hit_skip ? {26'd0, cpu_clock_select_reg, skip_pen, skip_done,
		skip_busy} : 32'h0000_0000;
	assign prdata = rd_val;

	// ==========================================================
	// checks
	a_direct_low_bank: assert property (@(posedge pclk) disable iff
		(!presetn) (kind == oask_pkg::OASK_OP_MEM &&
		!data_bank_enable_flag && val[7:0] <= 8'h7F) |->
		result.bank == 4'h0) else $error("direct low bank wrong"); // RULE4
	a_dedl_bank: assert property (@(posedge pclk) disable iff (!presetn)
		(kind == oask_pkg::OASK_OP_IND1) |-> result.bank == 4'h0)
		else $error("de/dl bank not zero"); // RULE5
	a_bit_bank: assert property (@(posedge pclk) disable iff (!presetn)
		(kind == oask_pkg::OASK_OP_PMEM) |-> result.bank == 4'hF)
		else $error("port bit bank not 15"); // RULE6
	a_non_accumulator_register_noacc: assert property (@(posedge pclk) disable iff (!presetn)
		(kind == oask_pkg::OASK_OP_NON_ACCUMULATOR_REGISTER && sel == 3'd1) |-> !result.legal)
		else $error("accumulator accepted"); // RULE11
	a_rel_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(kind == oask_pkg::OASK_OP_REL && val[4:0] <= 5'd1) |->
		!result.legal) else $error("rel 0/+1 accepted"); // RULE18
	a_taddr_odd: assert property (@(posedge pclk) disable iff (!presetn)
		(kind == oask_pkg::OASK_OP_TADDR && val[0]) |-> !result.legal)
		else $error("odd call table accepted"); // RULE15
	a_extended_absolute_operand_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(kind == oask_pkg::OASK_OP_EXTENDED_ABSOLUTE_OPERAND && !enhanced_instruction_mode)
		|-> !result.legal) else $error("extended_absolute_operand in compat"); // RULE19
	a_long_skip: assert property (@(posedge pclk) disable iff (!presetn)
		(start && skip_req && next_long) |=> skip_busy ##1 skip_busy
		##1 !skip_busy) else $error("long skip not 2"); // RULE1
endmodule : oask_decoder

// ===== sim/testbench.sv
// testbench: apb-driven checks of operand decode and skip timing
`timescale 1ns/10ps
module testbench;
	// ==========================================================
	// signals and counters
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          bad_count;
	int          compares;

	// one decode case: ctrl, kind code, selector, value, expectation
	// exp[5] legal, exp[4] bank checked, exp[3:0] bank
	typedef struct packed {
		logic [11:0] ctrl;
		logic [3:0]  kind;
		logic [2:0]  sel;
		logic [12:0] val;
		logic [5:0]  exp;
	} oask_case_t;

	// kind codes follow the package enum order (ind=4, mem=6, ...)
	oask_case_t cases [37] = '{
		'{12'h011, 4'h4, 3'h0, 13'h0000, 6'h31}, // gated select
		'{12'h011, 4'h4, 3'h3, 13'h0000, 6'h30}, // de pointer
		'{12'h011, 4'h4, 3'h4, 13'h0000, 6'h30}, // dl pointer
		'{12'h0F1, 4'h4, 3'h0, 13'h0000, 6'h3F}, // bank 15
		'{12'h010, 4'h4, 3'h0, 13'h0000, 6'h30}, // gate closed
		'{12'h010, 4'h6, 3'h0, 13'h007F, 6'h30}, // low half
		'{12'h010, 4'h6, 3'h0, 13'h0080, 6'h3F}, // high half
		'{12'h011, 4'h6, 3'h0, 13'h0080, 6'h31}, // flag set
		'{12'h011, 4'h7, 3'h0, 13'h0FB0, 6'h3F},
		'{12'h011, 4'h7, 3'h0, 13'h0FFF, 6'h3F}, // top
		'{12'h000, 4'h7, 3'h0, 13'h0FC0, 6'h00}, // gap
		'{12'h000, 4'h7, 3'h0, 13'h0FAF, 6'h00}, // below
		'{12'h011, 4'h8, 3'h0, 13'h0FC0, 6'h3F},
		'{12'h000, 4'h8, 3'h0, 13'h0FBF, 6'h00}, // below
		'{12'h000, 4'h1, 3'h1, 13'h0000, 6'h00}, // no a
		'{12'h000, 4'h1, 3'h0, 13'h0000, 6'h20}, // x ok
		'{12'h000, 4'h0, 3'h1, 13'h0000, 6'h20}, // a ok
		'{12'h000, 4'h3, 3'h0, 13'h0000, 6'h00}, // no xa
		'{12'h000, 4'h3, 3'h1, 13'h0000, 6'h20}, // bc ok
		'{12'h000, 4'h2, 3'h0, 13'h0000, 6'h20}, // xa ok
		'{12'h000, 4'h5, 3'h0, 13'h0000, 6'h00}, // no hl
		'{12'h000, 4'h5, 3'h3, 13'h0000, 6'h20}, // de ok
		'{12'h000, 4'hD, 3'h0, 13'h0020, 6'h20}, // bottom
		'{12'h000, 4'hD, 3'h0, 13'h0021, 6'h00}, // odd
		'{12'h000, 4'hD, 3'h0, 13'h007E, 6'h20}, // top
		'{12'h000, 4'hD, 3'h0, 13'h0080, 6'h00}, // above
		'{12'h000, 4'hD, 3'h0, 13'h001E, 6'h00}, // below
		'{12'h000, 4'hA, 3'h0, 13'h0100, 6'h00}, // compat
		'{12'h100, 4'hA, 3'h0, 13'h0100, 6'h20}, // enhanced
		'{12'h000, 4'hC, 3'h0, 13'h07FF, 6'h20}, // top
		'{12'h000, 4'hC, 3'h0, 13'h0800, 6'h00}, // above
		'{12'h000, 4'hE, 3'h0, 13'h0000, 6'h00}, // zero
		'{12'h000, 4'hE, 3'h0, 13'h0001, 6'h00}, // plus one
		'{12'h000, 4'hE, 3'h0, 13'h0002, 6'h20}, // plus two
		'{12'h000, 4'hE, 3'h0, 13'h0010, 6'h20}, // plus 16
		'{12'h000, 4'hE, 3'h0, 13'h0011, 6'h20}, // minus 15
		'{12'h000, 4'hE, 3'h0, 13'h001F, 6'h20}  // minus one
	};

	// ==========================================================
	// design under test
	oask_decoder i_oask_decoder (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	// 50 MHz clock
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// ==========================================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// one apb transfer; an idle edge first so no signal is set twice
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h0000_0001, 32'(pready));
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask : rd

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		rd(oask_pkg::ADDR_CTRL, r);
		chk("ctrl reset", oask_pkg::CTRL_RESET, r);
		rd(oask_pkg::ADDR_SKIP, r);
		chk("skip reset", 32'h0000_0000, r);
		// unmapped word is refused and reads zero
		apb(1'b0, 12'h014, 32'h0000_0000, r, e);
		chk("unmapped rdata", 32'h0000_0000, r);
		chk("unmapped err", 32'h0000_0001, 32'(e));
		apb(1'b1, 12'h014, 32'hFFFF_FFFF, r, e);
		chk("unmapped werr", 32'h0000_0001, 32'(e));
	endtask : t_reset

	task automatic t_table();
		logic [31:0] r;
		wr(oask_pkg::ADDR_PC, 32'h0000_0100);
		foreach (cases[i]) begin
			wr(oask_pkg::ADDR_CTRL, {20'h0_0000, cases[i].ctrl});
			wr(oask_pkg::ADDR_OPCODE, {cases[i].kind, 1'b0, cases[i].sel,
				2'b00, 9'h000, cases[i].val});
			rd(oask_pkg::ADDR_RESULT, r);
			chk("legal", 32'(cases[i].exp[5]), 32'(r[28]));
			if (cases[i].exp[4])
				chk("bank", 32'(cases[i].exp[3:0]), 32'(r[27:24]));
		end
	endtask : t_table

	// target address of in-page, short call and relative forms
	task automatic t_targets();
		logic [31:0] r;
		wr(oask_pkg::ADDR_CTRL, 32'h0001_0000);
		wr(oask_pkg::ADDR_PC, 32'h0000_1000);
		wr(oask_pkg::ADDR_OPCODE, 32'hB000_0123);
		rd(oask_pkg::ADDR_RESULT, r);
		chk("page addr", 32'h0000_1123, 32'(r[12:0]));
		wr(oask_pkg::ADDR_OPCODE, 32'hC000_07FF);
		rd(oask_pkg::ADDR_RESULT, r);
		chk("short call", 32'h0000_07FF, 32'(r[12:0]));
		wr(oask_pkg::ADDR_PC, 32'h0000_0100);
		wr(oask_pkg::ADDR_OPCODE, 32'hE000_0011);
		rd(oask_pkg::ADDR_RESULT, r);
		chk("rel back", 32'h0000_00F1, 32'(r[12:0]));
		wr(oask_pkg::ADDR_OPCODE, 32'hE000_0002);
		rd(oask_pkg::ADDR_RESULT, r);
		chk("rel fwd", 32'h0000_0102, 32'(r[12:0]));
		wr(oask_pkg::ADDR_OPCODE, 32'hE000_0010);
		rd(oask_pkg::ADDR_RESULT, r);
		chk("rel fwd16", 32'h0000_0110, 32'(r[12:0]));
		// pair-wide direct access kept on an even address
		wr(oask_pkg::ADDR_OPCODE, 32'h6000_0302);
		rd(oask_pkg::ADDR_RESULT, r);
		chk("even pair", 32'h0000_0000, 32'(r[31]));
		chk("bit field", 32'h0000_0003, 32'(r[23:22]));
	endtask : t_targets

	// skip of one-, two- and three-byte forms and no skip
	task automatic t_skip();
		logic [31:0] r;
		int          n;
		for (int i = 0; i < 4; i++) begin
			wr(oask_pkg::ADDR_PC, 32'h0000_0040);
			wr(oask_pkg::ADDR_OPCODE, {4'h0, i > 0, 3'h0, i == 3, i == 2,
				22'h00_0000});
			wr(oask_pkg::ADDR_SKIP, 32'h0000_0001);
			n = 0;
			do begin
				rd(oask_pkg::ADDR_SKIP, r);
				n++;
			end while (r[0] !== 1'b0 && n < 8);
			chk("penalty", (i == 0) ? 0 : (i == 3) ? 2 : 1, 32'(r[3:2]));
			rd(oask_pkg::ADDR_PC, r);
			chk("pc after skip", 32'h0000_0040 + i, r);
		end
	endtask : t_skip

	task automatic t_clock();
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			wr(oask_pkg::ADDR_CTRL, 32'(i) << 12);
			rd(oask_pkg::ADDR_SKIP, r);
			chk("clock select", 32'(i), 32'(r[5:4]));
		end
	endtask : t_clock

	// ==========================================================
	// verdict, watchdog and main sequence
	task automatic tally_and_finish();
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// the tests need about 500 cycles; allow far more
	initial begin
		#400_000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		bad_count = 0;
		compares  = 0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 12'h000;
		pwdata    = 32'h0000_0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_table();
		t_targets();
		t_skip();
		t_clock();
		tally_and_finish();
	end
endmodule : testbench
